// ==== include/scm_pkg.sv ====
// system clock and operating-mode controller: constants, modes and register map
// assumes an apb master on core_clk and oscillator pins sampled as plain inputs
package scm_pkg;

  // ----------------------------------------------------------------
  // divider geometry
  // ----------------------------------------------------------------
  localparam int PRE_W = 2;
  localparam int LOW_W = 6;
  localparam int DIV_W = 21;
  localparam int HIGH_W = DIV_W - LOW_W;
  localparam int WARM_BIT = 14;
  // time base taps, one 5-bit divider index per source select code
  localparam logic [39:0] TBT_TAPS = {5'h14, 5'h12, 5'h10, 5'h0E, 5'h0C, 5'h0A, 5'h08, 5'h06};

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SYS_ONE = 8'h00;
  localparam logic [7:0] OFS_SYS_TWO = 8'h04;
  localparam logic [7:0] OFS_TB_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_DIVIDER = 8'h10;

  localparam int B_STOP = 7;
  localparam int B_HIGH_EN = 7;
  localparam int B_LOW_EN = 6;
  localparam int B_SYSTEM_CLOCK_SELECT = 5;
  localparam int B_IDLE = 4;
  localparam int B_TIMING_GENERATOR_HALT = 2;
  localparam int B_DIVIDER_STAGE7_CLOCK_SELECT = 7;
  localparam int B_TBT_EN = 3;
  localparam int F_TBT_SEL_LO = 0;
  localparam int F_TBT_SEL_W = 3;

  localparam logic [7:0] RST_SYS_ONE = 8'h00;
  localparam logic [7:0] RST_SYS_TWO = 8'h80;
  localparam logic [7:0] RST_TB_CTRL = 8'h00;

  // ----------------------------------------------------------------
  // machine cycle states and operating modes
  // ----------------------------------------------------------------
  localparam logic [1:0] ST_S0 = 2'h0;
  localparam logic [1:0] ST_S3 = 2'h3;

  typedef enum logic [3:0] {
    SINGLE_NORMAL, SINGLE_IDLE, TIMER_ONLY_IDLE, DUAL_NORMAL, DUAL_IDLE,
    LOW_CPU_BOTH, LOW_ONLY, LOW_SLEEP, STOP_HALT, STOP_WARMUP
  } scm_mode_e;

endpackage : scm_pkg

// ==== core/scm_divider.sv ====
// prescaler and 21-stage divider of the timing generator
// assumes one-cycle tick inputs on core_clk for both oscillators
`timescale 1ns/1ps
module scm_divider
  import scm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // control
  input wire logic clear,
  input wire logic fc_tick,
  input wire logic fs_tick,
  input wire logic stage1_stop,
  input wire logic stage7_from_fs,
  // divider state
  output logic [DIV_W-1:0] div_q
);

  logic [PRE_W-1:0] pre;
  logic [LOW_W-1:0] low_q;
  logic [HIGH_W-1:0] high_q;
  logic pre_carry;
  logic low_carry;
  logic high_in;

  // ----------------------------------------------------------------
  // carry chain
  // ----------------------------------------------------------------
  assign pre_carry = fc_tick && !stage1_stop && (&pre);
  assign low_carry = pre_carry && (&low_q);
  assign high_in = stage7_from_fs ? fs_tick : low_carry;
  assign div_q = {high_q, low_q};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre <= '0;
    end else if (ce) begin
      if (clear) begin
        pre <= '0;
      end else if (fc_tick && !stage1_stop) begin
        pre <= pre + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_q <= '0;
    end else if (ce) begin
      if (clear) begin
        low_q <= '0;
      end else if (pre_carry) begin
        low_q <= low_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_q <= '0;
    end else if (ce) begin
      if (clear) begin
        high_q <= '0;
      end else if (high_in) begin
        high_q <= high_q + 1'b1;
      end
    end
  end

endmodule : scm_divider

// ==== core/scm_clock_mode.sv ====
// operating-mode controller with timing generator and apb register file
// assumes oscillator and stop-wake pins are asynchronous; interrupt inputs are on core_clk
`timescale 1ns/1ps
module scm_clock_mode
  import scm_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator and wake pins
  input wire logic high_freq_clock,
  input wire logic low_freq_clock,
  input wire logic stop_wake,
  // interrupt controller side
  input wire logic irq_request,
  input wire logic master_interrupt_enable,
  input wire logic time_base_interrupt_enable,
  output logic idle_wake_service,
  output logic idle_wake_continue,
  output logic time_base_interrupt_latch,
  output logic time_base_service,
  // clock enables and status to cpu and peripherals
  output logic cpu_clk_en,
  output logic wdt_clk_en,
  output logic periph_clk_en,
  output logic tbt_clk_en,
  output logic [1:0] machine_state,
  output logic high_osc_run,
  output logic low_osc_run,
  output logic low_pins_are_port,
  output logic [DIV_W-1:0] divider_value
);

  scm_mode_e mode;
  scm_mode_e next_mode;
  scm_mode_e ret_mode;
  logic [7:0] system_control_one;
  logic [7:0] system_control_two;
  logic [7:0] time_base_control;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [1:0] edge_q;
  logic fc_tick;
  logic fs_tick;
  logic wake_lvl;
  logic main_tick;
  logic cur_low;
  logic target_low;
  logic tb_prev;
  logic tb_now;
  logic tb_fall;
  logic tbt_en_saved;
  logic stop_from_normal;
  logic sel7_fs;
  logic stage1_stop;
  logic div_clear;
  logic wr_en;
  logic setup;
  logic [4:0] tap;
  logic high_en;
  logic low_en;

  // ----------------------------------------------------------------
  // pin synchronisers and edge ticks
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
      edge_q <= '0;
    end else if (ce) begin
      sync1 <= {stop_wake, low_freq_clock, high_freq_clock};
      sync2 <= sync1;
      edge_q <= sync2[1:0];
    end
  end

  assign high_en = system_control_two[B_HIGH_EN];
  assign low_en = system_control_two[B_LOW_EN];
  // oscillators idle in stop halt; high idles in other modes only when its enable bit is clear
  assign high_osc_run = high_en && mode != STOP_HALT;
  assign low_osc_run = low_en && mode != STOP_HALT;
  assign low_pins_are_port = !low_en;
  assign fc_tick = sync2[0] && !edge_q[0] && high_osc_run;
  assign fs_tick = sync2[1] && !edge_q[1] && low_osc_run;
  assign wake_lvl = sync2[2];

  // ----------------------------------------------------------------
  // main system clock and machine cycle
  // ----------------------------------------------------------------
  assign target_low = mode inside {LOW_CPU_BOTH, LOW_ONLY, LOW_SLEEP};
  assign main_tick = cur_low ? fs_tick : fc_tick;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      machine_state <= ST_S0;
    end else if (ce && main_tick) begin
      machine_state <= machine_state + 2'h1;
    end
  end

  // source only swaps when S3 completes, so no state is cut short
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_low <= 1'b0;
    end else if (ce && main_tick && machine_state == ST_S3) begin
      cur_low <= target_low;
    end
  end

  assign cpu_clk_en = main_tick && (mode inside {SINGLE_NORMAL, DUAL_NORMAL,
                      LOW_CPU_BOTH, LOW_ONLY});
  assign wdt_clk_en = cpu_clk_en;
  assign periph_clk_en = main_tick && !(mode inside {TIMER_ONLY_IDLE, STOP_HALT,
                         STOP_WARMUP});
  assign tbt_clk_en = main_tick && !(mode inside {STOP_HALT, STOP_WARMUP});

  // ----------------------------------------------------------------
  // divider and stage-7 source
  // ----------------------------------------------------------------
  // software must keep the select low in single-clock mode
  assign sel7_fs = (mode inside {LOW_CPU_BOTH, LOW_ONLY, LOW_SLEEP}) ? 1'b1 :
                   (mode == STOP_WARMUP && stop_from_normal) ? 1'b0 :
                   time_base_control[B_DIVIDER_STAGE7_CLOCK_SELECT];
  assign stage1_stop = mode inside {LOW_ONLY, LOW_SLEEP};
  assign div_clear = (next_mode == STOP_HALT && mode != STOP_HALT) ||
                     (mode == STOP_HALT && next_mode != STOP_HALT);

  scm_divider u_div (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .clear(div_clear),
    .fc_tick(fc_tick),
    .fs_tick(fs_tick),
    .stage1_stop(stage1_stop),
    .stage7_from_fs(sel7_fs),
    .div_q(divider_value)
  );

  assign tap = TBT_TAPS[time_base_control[F_TBT_SEL_LO +: F_TBT_SEL_W] * 5 +: 5];
  assign tb_now = divider_value[tap];
  assign tb_fall = tb_prev && !tb_now;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tb_prev <= 1'b0;
    end else if (ce) begin
      tb_prev <= tb_now;
    end
  end

  // ----------------------------------------------------------------
  // operating mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    unique case (mode)
      SINGLE_NORMAL, DUAL_NORMAL: begin
        if (system_control_one[B_STOP]) begin
          next_mode = STOP_HALT;
        end else if (system_control_two[B_IDLE]) begin
          next_mode = low_en ? DUAL_IDLE : SINGLE_IDLE;
        end else if (system_control_two[B_TIMING_GENERATOR_HALT]) begin
          next_mode = TIMER_ONLY_IDLE;
        end else if (low_en && system_control_two[B_SYSTEM_CLOCK_SELECT]) begin
          next_mode = LOW_CPU_BOTH;
        end else begin
          next_mode = low_en ? DUAL_NORMAL : SINGLE_NORMAL;
        end
      end
      SINGLE_IDLE: if (irq_request) next_mode = SINGLE_NORMAL;
      DUAL_IDLE: if (irq_request) next_mode = DUAL_NORMAL;
      TIMER_ONLY_IDLE: if (tb_fall) next_mode = SINGLE_NORMAL;
      LOW_CPU_BOTH: begin
        if (system_control_one[B_STOP]) begin
          next_mode = STOP_HALT;
        end else if (system_control_two[B_IDLE]) begin
          next_mode = LOW_SLEEP;
        end else if (!system_control_two[B_SYSTEM_CLOCK_SELECT]) begin
          next_mode = DUAL_NORMAL;
        end else if (!high_en && cur_low) begin
          next_mode = LOW_ONLY;
        end
      end
      LOW_ONLY: begin
        if (system_control_one[B_STOP]) begin
          next_mode = STOP_HALT;
        end else if (system_control_two[B_IDLE]) begin
          next_mode = LOW_SLEEP;
        end else if (high_en) begin
          next_mode = LOW_CPU_BOTH;
        end
      end
      LOW_SLEEP: if (irq_request) next_mode = high_en ? LOW_CPU_BOTH : LOW_ONLY;
      STOP_HALT: if (wake_lvl) next_mode = STOP_WARMUP;
      STOP_WARMUP: if (divider_value[WARM_BIT]) next_mode = ret_mode;
      default: next_mode = SINGLE_NORMAL;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= SINGLE_NORMAL;
    end else if (ce) begin
      mode <= next_mode;
    end
  end

  // remember the mode stop was entered from, for warm-up and return
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ret_mode <= SINGLE_NORMAL;
      stop_from_normal <= 1'b0;
    end else if (ce && next_mode == STOP_HALT && mode != STOP_HALT) begin
      ret_mode <= mode;
      stop_from_normal <= mode inside {SINGLE_NORMAL, DUAL_NORMAL};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tbt_en_saved <= 1'b0;
    end else if (ce && next_mode == TIMER_ONLY_IDLE && mode != TIMER_ONLY_IDLE) begin
      tbt_en_saved <= time_base_control[B_TBT_EN];
    end
  end

  // ----------------------------------------------------------------
  // wake-up events towards the interrupt controller
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_wake_service <= 1'b0;
      idle_wake_continue <= 1'b0;
      time_base_interrupt_latch <= 1'b0;
      time_base_service <= 1'b0;
    end else if (ce) begin
      idle_wake_service <= 1'b0;
      idle_wake_continue <= 1'b0;
      time_base_interrupt_latch <= 1'b0;
      time_base_service <= 1'b0;
      if ((mode inside {SINGLE_IDLE, DUAL_IDLE, LOW_SLEEP}) && irq_request) begin
        idle_wake_service <= master_interrupt_enable;
        idle_wake_continue <= !master_interrupt_enable;
      end
      if (mode == TIMER_ONLY_IDLE && tb_fall) begin
        time_base_interrupt_latch <= tbt_en_saved;
        time_base_service <= tbt_en_saved && master_interrupt_enable &&
                             time_base_interrupt_enable;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_en = ce && psel && penable && pwrite;
  assign pready = ce;

  // a write in the same cycle as a hardware clear wins: software intent is newer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      system_control_one <= RST_SYS_ONE;
      system_control_two <= RST_SYS_TWO;
      time_base_control <= RST_TB_CTRL;
    end else if (ce) begin
      if (mode == STOP_WARMUP && next_mode != STOP_WARMUP) begin
        system_control_one[B_STOP] <= 1'b0;
      end
      if (mode inside {SINGLE_IDLE, DUAL_IDLE, LOW_SLEEP} && irq_request) begin
        system_control_two[B_IDLE] <= 1'b0;
      end
      if (mode == TIMER_ONLY_IDLE && tb_fall) begin
        system_control_two[B_TIMING_GENERATOR_HALT] <= 1'b0;
      end
      if (wr_en && paddr == OFS_SYS_ONE) system_control_one <= pwdata[7:0];
      if (wr_en && paddr == OFS_SYS_TWO) system_control_two <= pwdata[7:0];
      if (wr_en && paddr == OFS_TB_CTRL) time_base_control <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      pslverr <= 1'b0;
      unique case (paddr)
        OFS_SYS_ONE: prdata <= {24'h000000, system_control_one};
        OFS_SYS_TWO: prdata <= {24'h000000, system_control_two};
        OFS_TB_CTRL: prdata <= {24'h000000, time_base_control};
        OFS_STATUS: prdata <= {25'h0000000, cur_low, machine_state, mode};
        OFS_DIVIDER: prdata <= {11'h000, divider_value};
        default: begin
          prdata <= '0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  reset_mode_a: assert property (@(posedge core_clk) $rose(rst_b) |-> mode == SINGLE_NORMAL)
    else $error("mode after reset is not single-clock normal");
  idle_wake_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode == SINGLE_IDLE && irq_request && ce) |=> mode == SINGLE_NORMAL)
    else $error("single-clock idle not released by interrupt");
  tb_return_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode == TIMER_ONLY_IDLE && tb_fall && ce) |=>
    (mode == SINGLE_NORMAL && time_base_interrupt_latch == $past(tbt_en_saved)))
    else $error("timer-only idle return or latch wrong");
  halt_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    mode == TIMER_ONLY_IDLE |-> !periph_clk_en && !cpu_clk_en)
    else $error("clocks leak in timer-only idle");
  low_stage7_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode inside {LOW_CPU_BOTH, LOW_ONLY, LOW_SLEEP}) |-> sel7_fs)
    else $error("stage seven not on low clock in slow mode");
  warm_stage6_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode == STOP_WARMUP && stop_from_normal) |-> !sel7_fs)
    else $error("warm-up not fed from stage six");
  stage1_stop_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode inside {LOW_ONLY, LOW_SLEEP}) && ce && !div_clear |=> $stable(divider_value[LOW_W-1:0]))
    else $error("low divider stages run in low-only mode");
  state_step_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (main_tick && ce) |=> machine_state == 2'($past(machine_state) + 2'h1))
    else $error("machine state did not advance by one");
  switch_edge_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(cur_low) |-> machine_state == ST_S0)
    else $error("main clock source changed inside a machine cycle");
  stop_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ce && mode != STOP_HALT && next_mode == STOP_HALT) |=> divider_value == '0)
    else $error("divider not cleared on stop entry");

endmodule : scm_clock_mode

// ==== dv/scm_cpu_model.sv ====
// cpu and peripheral stand-in: counts clock enables and raises a request
// assumes wake_req and delay are driven by the bench on core_clk
`timescale 1ns/1ps
module scm_cpu_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // enables from the controller
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  // bench side
  input wire logic wake_req,
  input wire logic [7:0] delay,
  output logic irq_request,
  output logic [15:0] cpu_cnt,
  output logic [15:0] per_cnt
);
  logic [7:0] wait_cnt;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_cnt <= 16'h0000;
      per_cnt <= 16'h0000;
    end else begin
      cpu_cnt <= cpu_cnt + {15'h0000, cpu_clk_en};
      per_cnt <= per_cnt + {15'h0000, periph_clk_en};
    end
  end

  // request held until the bench withdraws it, like a pending flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 8'h00;
    end else if (!wake_req) begin
      wait_cnt <= 8'h00;
    end else if (wait_cnt != delay) begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
  assign irq_request = wake_req && (wait_cnt == delay);
endmodule : scm_cpu_model

// ==== dv/system_clock_mode_controller_tb_top.sv ====
// self-checking bench for the clock and mode controller
// assumes apb master on core_clk, free-running oscillators, no long counts
`timescale 1ns/1ps
module system_clock_mode_controller_tb_top import scm_pkg::*;;
  logic core_clk = 0, rst_b = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, delay = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic high_freq_clock = 0, low_freq_clock = 0, stop_wake = 0, wake_req = 0, clr = 0;
  logic master_interrupt_enable = 0, time_base_interrupt_enable = 0;
  logic pready, pslverr, irq_request, idle_wake_service, idle_wake_continue;
  logic time_base_interrupt_latch, time_base_service, cpu_clk_en, periph_clk_en;
  logic high_osc_run, low_osc_run, low_pins_are_port;
  logic [1:0] machine_state, prev_ms = 2'h0;
  logic [DIV_W-1:0] divider_value;
  logic [15:0] cpu_cnt, per_cnt, c0, p0;
  logic [5:0] d0;
  logic [DIV_W-1:0] dv0;
  logic [3:0] seen = 4'h0;
  logic [1:0] tc [3] = '{2'b11, 2'b01, 2'b10};
  logic [32:0] exp_q[$], msk_q[$], e;
  int n_fail = 0, samples_checked = 0;

  scm_clock_mode u_scm_clock_mode (.core_clk, .rst_b, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .high_freq_clock, .low_freq_clock,
    .stop_wake, .irq_request, .master_interrupt_enable, .time_base_interrupt_enable,
    .idle_wake_service, .idle_wake_continue, .time_base_interrupt_latch,
    .time_base_service, .cpu_clk_en, .wdt_clk_en(), .periph_clk_en, .tbt_clk_en(),
    .machine_state, .high_osc_run, .low_osc_run, .low_pins_are_port, .divider_value);
  scm_cpu_model u_scm_cpu_model (.core_clk, .rst_b, .cpu_clk_en, .periph_clk_en,
    .wake_req, .delay, .irq_request, .cpu_cnt, .per_cnt);

  initial forever #4 core_clk = ~core_clk;
  initial forever #16 high_freq_clock = ~high_freq_clock;
  initial forever #100 low_freq_clock = ~low_freq_clock;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] s, input logic [32:0] x);
    samples_checked++;
    if (s !== x) begin
      n_fail++;
      $display("MISMATCH %0t seen %h want %h", $time, s, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] x, input logic [32:0] m);
    @(posedge core_clk);
    if (!w) begin
      exp_q.push_back(x);
      msk_q.push_back(m);
    end
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no wait-state count assumed; only the watchdog ends a hung access
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask : wr

  task automatic rd_mode(input logic [3:0] md);
    apb(1'b0, OFS_STATUS, 32'h0, {29'h0, md}, 33'h1_0000_000F);
  endtask : rd_mode

  task automatic wait_seen(input int i);
    int k;
    k = 0;
    while (seen[i] !== 1'b1 && k < 500) begin
      @(posedge core_clk);
      k++;
    end
  endtask : wait_seen

  task automatic stop_test;
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // output watcher: read results, state sequence, wake pulses
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk({pslverr, prdata} & msk_q.pop_front(), e);
    end
    if (rst_b && machine_state !== prev_ms) chk(machine_state, 2'(prev_ms + 2'h1));
    prev_ms <= machine_state;
    seen <= clr ? 4'h0 : seen | {idle_wake_service, idle_wake_continue,
                                 time_base_interrupt_latch, time_base_service};
  end

  initial begin
    #400000;
    chk(1'b0, 1'b1);
    stop_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h70B9));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, OFS_SYS_TWO, 32'h0, 33'h80, {33{1'b1}});
    chk({low_pins_are_port, high_osc_run, low_osc_run}, 3'b110);
    apb(1'b0, 8'h14, 32'h0, 33'h1_0000_0000, {33{1'b1}});
    wr(OFS_STATUS, $urandom());
    wr(8'h14, $urandom());
    rd_mode(SINGLE_NORMAL);
    // clock enable low must freeze the divider
    ce <= 1'b0;
    @(posedge core_clk);
    dv0 = divider_value;
    repeat (20) @(posedge core_clk);
    chk(divider_value, dv0);
    ce <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      master_interrupt_enable <= i[0];
      clr <= 1'b1;
      wr(OFS_SYS_TWO, 32'h90);
      clr <= 1'b0;
      rd_mode(SINGLE_IDLE);
      c0 = cpu_cnt;
      p0 = per_cnt;
      repeat (8) @(posedge core_clk);
      chk({cpu_cnt, per_cnt != p0}, {c0, 1'b1});
      delay <= 8'($urandom_range(10, 60));
      wake_req <= 1'b1;
      wait_seen(2 + i);
      wake_req <= 1'b0;
      chk(seen[3:2], i[0] ? 2'b10 : 2'b01);
      rd_mode(SINGLE_NORMAL);
    end
    time_base_interrupt_enable <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      master_interrupt_enable <= tc[i][0];
      // stage-7 select stays low in single mode
      wr(OFS_TB_CTRL, {28'h0, tc[i][1], 3'h0});
      clr <= 1'b1;
      wr(OFS_SYS_TWO, 32'h84);
      clr <= 1'b0;
      // let the last normal-mode tick land before taking the baseline
      repeat (2) @(posedge core_clk);
      c0 = cpu_cnt;
      p0 = per_cnt;
      repeat (4) @(posedge core_clk);
      chk({cpu_cnt, per_cnt}, {c0, p0});
      for (int k = 0; k < 20000 && cpu_cnt == c0; k++) @(posedge core_clk);
      repeat (8) @(posedge core_clk);
      chk(seen[1:0], {tc[i][1], &tc[i]});
      rd_mode(SINGLE_NORMAL);
    end
    wr(OFS_SYS_TWO, 32'hC0);
    repeat (400) @(posedge core_clk);
    chk({low_pins_are_port, low_osc_run}, 2'b01);
    rd_mode(DUAL_NORMAL);
    wr(OFS_SYS_TWO, 32'hE0);
    repeat (400) @(posedge core_clk);
    rd_mode(LOW_CPU_BOTH);
    // low oscillator enable kept set in low_cpu_both_osc_mode
    wr(OFS_SYS_TWO, 32'h60);
    repeat (400) @(posedge core_clk);
    rd_mode(LOW_ONLY);
    d0 = divider_value[5:0];
    repeat (100) @(posedge core_clk);
    chk({high_osc_run, divider_value[5:0]}, {1'b0, d0});
    wr(OFS_SYS_TWO, 32'hE0);
    repeat (400) @(posedge core_clk);
    wr(OFS_SYS_TWO, 32'hC0);
    repeat (400) @(posedge core_clk);
    rd_mode(DUAL_NORMAL);
    master_interrupt_enable <= 1'b0;
    wr(OFS_SYS_TWO, 32'hD0);
    rd_mode(DUAL_IDLE);
    wake_req <= 1'b1;
    wait_seen(2);
    wake_req <= 1'b0;
    chk(seen[3:2], 2'b01);
    rd_mode(DUAL_NORMAL);
    wr(OFS_SYS_ONE, 32'h80);
    repeat (4) @(posedge core_clk);
    rd_mode(STOP_HALT);
    chk(divider_value, 21'h0);
    stop_wake <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd_mode(STOP_WARMUP);
    stop_wake <= 1'b0;
    repeat (1200) @(posedge core_clk);
    chk(divider_value[DIV_W-1:LOW_W] != '0, 1'b1);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_mode(SINGLE_NORMAL);
    apb(1'b0, OFS_SYS_TWO, 32'h0, 33'h80, {33{1'b1}});
    // let the watcher take the last read before closing
    repeat (2) @(posedge core_clk);
    chk(exp_q.size(), 0);
    stop_test();
  end
endmodule : system_clock_mode_controller_tb_top
